/* File: verilog/prs_pkg.sv */
// prs_pkg: shared constants and types for the power-up / reset sequencer link.
// assumes both ends run on one clock, clk_sys, at 100 MHz.
package prs_pkg;
    localparam int PRS_NUM_POR = 4;
    localparam int PRS_NUM_LSRST = 3;
    localparam int PRS_ADDR_W = 16;
    localparam int PRS_DATA_W = 16;
    localparam logic [15:0] PRS_ADDR_PLL_FEEDBACK = 16'hf000;
    localparam logic [15:0] PRS_ADDR_PLL_PRESCALE = 16'hf001;
    localparam logic [15:0] PRS_ADDR_CLK_SOURCE = 16'hf002;
    localparam logic [15:0] PRS_ADDR_PLL_RUN = 16'hf003;
    localparam logic [15:0] PRS_ADDR_PLL_LOCKED = 16'hf004;
    localparam int PRS_LOCK_BIT = 0;
    localparam int PRS_RUN_BIT = 0;
    localparam logic [15:0] PRS_FEEDBACK_RESET = 16'h0060;
    localparam logic [15:0] PRS_ZERO_RESET = 16'h0000;
    // por index: 0 io_supply, 1 core_supply, 2 pll_supply, 3 analog_supply
    localparam int PRS_POR_IO = 0;
    localparam int PRS_POR_CORE = 1;
    localparam int PRS_POR_PLL = 2;
    localparam int PRS_POR_ANALOG = 3;
    // level-shifter reset index
    localparam int PRS_LS_IO = 0;
    localparam int PRS_LS_PLL = 1;
    localparam int PRS_LS_ANALOG = 2;
    localparam int PRS_ROM_STEPS = 8;
    localparam int PRS_LOCK_MAX_CYCLES = 32768;
    localparam int PRS_SS_TOGGLES = 3;
    localparam int PRS_MCLK_PERIOD_NS = 10;
    localparam int PRS_CLK_NS = 10;
    localparam int PRS_SS_MIN_CYCLES = (PRS_MCLK_PERIOD_NS + PRS_CLK_NS - 1) / PRS_CLK_NS;
    typedef enum logic [1:0] {
        PRS_PORT_I2C,
        PRS_PORT_SPI
    } prs_port_mode_e;
endpackage : prs_pkg

/* File: verilog/prs_link_if.sv */
// prs_link_if: pins between the sequencer device and its host.
// assumes a single clock shared by both ends; no tristate pins here.
`timescale 1ns/1ps
interface prs_link_if;
    import prs_pkg::*;
    logic [PRS_NUM_POR-1:0] porGood;
    logic resetPinN;
    logic masterClockValid;
    logic bootFromEepromStrap;
    logic slaveSelectAddressPin;
    logic wrStb;
    logic rdStb;
    logic [PRS_ADDR_W-1:0] addr;
    logic [PRS_DATA_W-1:0] wrData;
    logic [PRS_DATA_W-1:0] rdData;
    logic rdValid;
    logic portActive;
    logic selfBootBusy;
    modport device (
        input porGood, resetPinN, masterClockValid, bootFromEepromStrap, slaveSelectAddressPin,
        input wrStb, rdStb, addr, wrData,
        output rdData, rdValid, portActive, selfBootBusy
    );
    modport host (
        output porGood, resetPinN, masterClockValid, bootFromEepromStrap, slaveSelectAddressPin,
        output wrStb, rdStb, addr, wrData,
        input rdData, rdValid, portActive, selfBootBusy
    );
endinterface : prs_link_if

/* File: verilog/prs_device.sv */
// prs_device: power-up and reset sequencer of the audio processor end.
// assumes link pins come from outside the clock domain; power, reset, clock, strap and select pins are synchronised here, strobes, addr and data are not.
// Operation
// - hold core reset until all release conditions
// - core leaves reset after io level shifter release
// - merge power-goods into three level-shifter resets
// - gate master clock to pll until ready
// - run eight-cycle rom init after reset
// - pll registers writable only after rom
// - pll locks within 32768 prescaled cycles
// - lock status bit 0 at 0xf004
// - control port dead while pll locks
// - host supplies valid clock by core stable
// - strap high starts self boot, host waits
// - host toggles slave select three times
// - each toggle lasts one master clock
// - spi mode at third select rising edge
// - host then writes operating configuration
`timescale 1ns/1ps
module prs_device #(
    parameter int LockCycles = prs_pkg::PRS_LOCK_MAX_CYCLES,
    parameter int BootCycles = 64
) (
    input wire logic clk_sys,
    input wire logic rst,
    prs_link_if.device link,
    output logic [prs_pkg::PRS_NUM_LSRST-1:0] levelShiftRst,
    output logic coreRst,
    output logic pllClockGate,
    output logic romDone,
    output logic pllLocked,
    output prs_pkg::prs_port_mode_e portMode,
    output logic [prs_pkg::PRS_DATA_W-1:0] pllFeedback,
    output logic [prs_pkg::PRS_DATA_W-1:0] pllPrescale,
    output logic [prs_pkg::PRS_DATA_W-1:0] clockSource,
    output logic pllRun
);
    import prs_pkg::*;

    typedef enum logic [2:0] {
        PRS_ST_RESET,
        PRS_ST_ROM,
        PRS_ST_BOOT,
        PRS_ST_CONFIG,
        PRS_ST_LOCKING,
        PRS_ST_READY
    } prs_state_e;

    localparam int SyncW = PRS_NUM_POR + 4;
    localparam int LockW = $clog2(LockCycles + 1);
    localparam int BootW = $clog2(BootCycles + 1);
    localparam int RomW = $clog2(PRS_ROM_STEPS + 1);

    logic [SyncW-1:0] syncA_q;
    logic [SyncW-1:0] syncB_q;
    logic [PRS_NUM_POR-1:0] porS;
    logic resetPinS, clockValidS, strapS, ssS;
    prs_state_e state_q;
    logic [RomW-1:0] romCnt_q;
    logic [LockW-1:0] lockCnt_q;
    logic [BootW-1:0] bootCnt_q;
    logic ssPrev_q;
    logic [1:0] ssRise_q;
    logic releaseOk;
    logic portOpen;

    // pins are asynchronous to clk_sys; second stage is the only reader of the first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {link.porGood, link.resetPinN, link.masterClockValid,
                        link.bootFromEepromStrap, link.slaveSelectAddressPin};
            syncB_q <= syncA_q;
        end
    end
    assign porS = syncB_q[SyncW-1 -: PRS_NUM_POR];
    assign resetPinS = syncB_q[3];
    assign clockValidS = syncB_q[2];
    assign strapS = syncB_q[1];
    assign ssS = syncB_q[0];

    // each crossing stays reset until its own domain and the core domain are good
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            levelShiftRst <= '1;
        end else begin
            levelShiftRst[PRS_LS_IO] <= !(porS[PRS_POR_IO] && porS[PRS_POR_CORE]);
            levelShiftRst[PRS_LS_PLL] <= !(porS[PRS_POR_PLL] && porS[PRS_POR_CORE]);
            levelShiftRst[PRS_LS_ANALOG] <= !(porS[PRS_POR_ANALOG] && porS[PRS_POR_CORE]);
        end
    end

    // io shifter release already implies io and core good; the rest complete the set
    assign releaseOk = !levelShiftRst[PRS_LS_IO] && (&porS) && clockValidS && resetPinS;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pllClockGate <= 1'b0;
        end else begin
            pllClockGate <= porS[PRS_POR_CORE] && !levelShiftRst[PRS_LS_PLL] && clockValidS;
        end
    end

    // losing any release condition drops the core back into reset at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= PRS_ST_RESET;
        end else if (!releaseOk) begin
            state_q <= PRS_ST_RESET;
        end else begin
            unique case (state_q)
                PRS_ST_RESET: state_q <= PRS_ST_ROM;
                PRS_ST_ROM: begin
                    if (romCnt_q == RomW'(PRS_ROM_STEPS - 1)) begin
                        state_q <= strapS ? PRS_ST_BOOT : PRS_ST_CONFIG;
                    end
                end
                PRS_ST_BOOT: begin
                    if (bootCnt_q == BootW'(BootCycles - 1)) begin
                        state_q <= PRS_ST_CONFIG;
                    end
                end
                PRS_ST_CONFIG: begin
                    if (pllRun) begin
                        state_q <= PRS_ST_LOCKING;
                    end
                end
                PRS_ST_LOCKING: begin
                    if (lockCnt_q == LockW'(LockCycles - 1)) begin
                        state_q <= PRS_ST_READY;
                    end
                end
                PRS_ST_READY: begin
                    if (!pllRun) begin
                        state_q <= PRS_ST_CONFIG;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            romCnt_q <= '0;
            bootCnt_q <= '0;
            lockCnt_q <= '0;
        end else begin
            romCnt_q <= (state_q == PRS_ST_ROM) ? romCnt_q + RomW'(1) : '0;
            bootCnt_q <= (state_q == PRS_ST_BOOT) ? bootCnt_q + BootW'(1) : '0;
            // lock model uses clk_sys as the prescaled pll input; worst case is the bound
            lockCnt_q <= (state_q == PRS_ST_LOCKING) ? lockCnt_q + LockW'(1) : '0;
        end
    end

    assign coreRst = (state_q == PRS_ST_RESET);
    assign romDone = (state_q == PRS_ST_BOOT) || (state_q == PRS_ST_CONFIG) ||
                     (state_q == PRS_ST_LOCKING) || (state_q == PRS_ST_READY);
    assign pllLocked = (state_q == PRS_ST_READY);
    assign portOpen = (state_q == PRS_ST_CONFIG) || (state_q == PRS_ST_READY);
    assign link.portActive = portOpen;
    assign link.selfBootBusy = (state_q == PRS_ST_BOOT);

    // spi select: count rising edges of the select pin; the length of each high phase is not checked
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ssPrev_q <= 1'b0;
            ssRise_q <= '0;
            portMode <= PRS_PORT_I2C;
        end else if (coreRst) begin
            ssPrev_q <= ssS;
            ssRise_q <= '0;
            portMode <= PRS_PORT_I2C;
        end else begin
            ssPrev_q <= ssS;
            if (portMode == PRS_PORT_I2C && ssS && !ssPrev_q) begin
                ssRise_q <= ssRise_q + 2'(1);
                if (ssRise_q == 2'(PRS_SS_TOGGLES - 1)) begin
                    portMode <= PRS_PORT_SPI;
                end
            end
        end
    end

    // pll registers; writes outside an open port are dropped silently
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pllFeedback <= PRS_FEEDBACK_RESET;
            pllPrescale <= PRS_ZERO_RESET;
            clockSource <= PRS_ZERO_RESET;
            pllRun <= 1'b0;
        end else if (coreRst) begin
            pllRun <= 1'b0;
        end else if (link.wrStb && portOpen) begin
            unique case (link.addr)
                PRS_ADDR_PLL_FEEDBACK: pllFeedback <= link.wrData;
                PRS_ADDR_PLL_PRESCALE: pllPrescale <= link.wrData;
                PRS_ADDR_CLK_SOURCE: clockSource <= link.wrData;
                PRS_ADDR_PLL_RUN: pllRun <= link.wrData[PRS_RUN_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.rdData <= '0;
            link.rdValid <= 1'b0;
        end else begin
            link.rdValid <= link.rdStb && portOpen;
            link.rdData <= '0;
            if (link.rdStb && portOpen) begin
                unique case (link.addr)
                    PRS_ADDR_PLL_FEEDBACK: link.rdData <= pllFeedback;
                    PRS_ADDR_PLL_PRESCALE: link.rdData <= pllPrescale;
                    PRS_ADDR_CLK_SOURCE: link.rdData <= clockSource;
                    PRS_ADDR_PLL_RUN: link.rdData <= PRS_DATA_W'(pllRun);
                    PRS_ADDR_PLL_LOCKED: link.rdData <= PRS_DATA_W'(pllLocked) << PRS_LOCK_BIT;
                    default: link.rdData <= '0;
                endcase
            end
        end
    end
endmodule : prs_device

/* File: verilog/prs_host.sv */
// prs_host: host end that powers the device up, selects the port and brings up the pll.
// assumes the device end answers on the same clock; user side gives power and settings.
`timescale 1ns/1ps
module prs_host #(
    parameter int PollGap = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    prs_link_if.host link,
    input wire logic [prs_pkg::PRS_NUM_POR-1:0] supplyGood,
    input wire logic clockRunning,
    input wire logic resetRequestN,
    input wire logic bootStrap,
    input wire logic wantSpi,
    input wire logic start,
    input wire logic [prs_pkg::PRS_DATA_W-1:0] feedbackValue,
    input wire logic [prs_pkg::PRS_DATA_W-1:0] prescaleValue,
    input wire logic [prs_pkg::PRS_DATA_W-1:0] sourceValue,
    output logic busy,
    output logic configured
);
    import prs_pkg::*;

    typedef enum logic [2:0] {
        PRS_H_IDLE,
        PRS_H_WAIT_BOOT,
        PRS_H_TOGGLE,
        PRS_H_WRITE,
        PRS_H_POLL,
        PRS_H_WAIT_READ,
        PRS_H_DONE
    } prs_host_state_e;

    localparam int GapW = $clog2(PollGap + PRS_SS_MIN_CYCLES + 2);

    prs_host_state_e state_q;
    logic [2:0] step_q;
    logic [GapW-1:0] gap_q;

    function automatic logic [PRS_ADDR_W-1:0] writeAddr(input logic [2:0] idx);
        unique case (idx)
            3'h0: writeAddr = PRS_ADDR_PLL_FEEDBACK;
            3'h1: writeAddr = PRS_ADDR_PLL_PRESCALE;
            3'h2: writeAddr = PRS_ADDR_CLK_SOURCE;
            default: writeAddr = PRS_ADDR_PLL_RUN;
        endcase
    endfunction : writeAddr

    // user's view of power and clock passes straight to the pins
    assign link.porGood = supplyGood;
    assign link.masterClockValid = clockRunning;
    assign link.resetPinN = resetRequestN;
    assign link.bootFromEepromStrap = bootStrap;
    assign busy = (state_q != PRS_H_IDLE) && (state_q != PRS_H_DONE);
    assign configured = (state_q == PRS_H_DONE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= PRS_H_IDLE;
            step_q <= '0;
            gap_q <= '0;
            link.slaveSelectAddressPin <= 1'b1;
            link.wrStb <= 1'b0;
            link.rdStb <= 1'b0;
            link.addr <= '0;
            link.wrData <= '0;
        end else begin
            link.wrStb <= 1'b0;
            link.rdStb <= 1'b0;
            unique case (state_q)
                PRS_H_IDLE: begin
                    step_q <= '0;
                    gap_q <= '0;
                    if (start) begin
                        state_q <= PRS_H_WAIT_BOOT;
                    end
                end
                PRS_H_WAIT_BOOT: begin
                    // port opens only after rom and any self boot are over
                    if (link.portActive && !link.selfBootBusy) begin
                        state_q <= wantSpi ? PRS_H_TOGGLE : PRS_H_WRITE;
                    end
                end
                PRS_H_TOGGLE: begin
                    // six phases, each held a few cycles so the synchroniser sees it
                    gap_q <= gap_q + GapW'(1);
                    if (gap_q == GapW'(PRS_SS_MIN_CYCLES + 2)) begin
                        gap_q <= '0;
                        link.slaveSelectAddressPin <= !link.slaveSelectAddressPin;
                        step_q <= step_q + 3'(1);
                        if (step_q == 3'(2 * PRS_SS_TOGGLES - 1)) begin
                            step_q <= '0;
                            state_q <= PRS_H_WRITE;
                        end
                    end
                end
                PRS_H_WRITE: begin
                    link.wrStb <= 1'b1;
                    link.addr <= writeAddr(step_q);
                    unique case (step_q)
                        3'h0: link.wrData <= feedbackValue;
                        3'h1: link.wrData <= prescaleValue;
                        3'h2: link.wrData <= sourceValue;
                        default: link.wrData <= PRS_DATA_W'(1) << PRS_RUN_BIT;
                    endcase
                    step_q <= step_q + 3'(1);
                    if (step_q == 3'h3) begin
                        state_q <= PRS_H_POLL;
                    end
                end
                PRS_H_POLL: begin
                    gap_q <= gap_q + GapW'(1);
                    if (gap_q >= GapW'(PollGap) && link.portActive) begin
                        gap_q <= '0;
                        link.rdStb <= 1'b1;
                        link.addr <= PRS_ADDR_PLL_LOCKED;
                        state_q <= PRS_H_WAIT_READ;
                    end
                end
                PRS_H_WAIT_READ: begin
                    if (link.rdValid) begin
                        state_q <= link.rdData[PRS_LOCK_BIT] ? PRS_H_DONE : PRS_H_POLL;
                    end else if (!link.portActive) begin
                        state_q <= PRS_H_POLL;
                    end
                end
                PRS_H_DONE: begin
                    if (!start) begin
                        state_q <= PRS_H_IDLE;
                    end
                end
                default: state_q <= PRS_H_IDLE;
            endcase
        end
    end
endmodule : prs_host

/* File: tb/prs_link_properties.sv */
// prs_link_properties: timing checks on the device/host link pins.
// assumes one clock and one async reset shared by both ends.
`timescale 1ns/1ps
module prs_link_properties #(
    parameter int LockCycles = prs_pkg::PRS_LOCK_MAX_CYCLES,
    parameter int BootCycles = 64
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [prs_pkg::PRS_NUM_POR-1:0] porGood,
    input wire logic resetPinN,
    input wire logic masterClockValid,
    input wire logic bootFromEepromStrap,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [prs_pkg::PRS_ADDR_W-1:0] addr,
    input wire logic [prs_pkg::PRS_DATA_W-1:0] wrData,
    input wire logic rdValid,
    input wire logic portActive,
    input wire logic selfBootBusy
);
    import prs_pkg::*;
    localparam int LockWin = LockCycles + 4;
    localparam int BootWin = BootCycles + 2;
    logic relOk;
    logic runWrite;
    logic [7:0] relCnt_q;
    assign relOk = (&porGood) && resetPinN && masterClockValid;
    assign runWrite = wrStb && portActive && addr == PRS_ADDR_PLL_RUN && wrData[PRS_RUN_BIT];
    // saturates so a long run never wraps back under the rom figure
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            relCnt_q <= 8'h00;
        end else if (!relOk) begin
            relCnt_q <= 8'h00;
        end else if (relCnt_q != 8'hff) begin
            relCnt_q <= relCnt_q + 8'h01;
        end
    end
    property p_read_answer;
        @(posedge clk_sys) disable iff (rst) rdStb && portActive |=> rdValid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read taken without answer");
    property p_read_cause;
        @(posedge clk_sys) disable iff (rst) rdValid |-> $past(rdStb) && $past(portActive);
    endproperty
    a_read_cause: assert property (p_read_cause) else $error("answer without open read");
    property p_release_lost;
        @(posedge clk_sys) disable iff (rst) !relOk |=> ##[0:4] !portActive;
    endproperty
    a_release_lost: assert property (p_release_lost) else $error("port open after release lost");
    property p_rom_first;
        @(posedge clk_sys) disable iff (rst) $rose(portActive) |-> relCnt_q >= 8'h0c;
    endproperty
    a_rom_first: assert property (p_rom_first) else $error("port opened before rom run");
    property p_lock_window;
        // the run bit lands on the write edge; the port closes one edge later
        @(posedge clk_sys) disable iff (rst) runWrite |=> ##1 !portActive [*8] ##[1:LockWin] portActive;
    endproperty
    a_lock_window: assert property (p_lock_window) else $error("lock window wrong");
    property p_boot_strap;
        @(posedge clk_sys) disable iff (rst) $rose(selfBootBusy) |-> bootFromEepromStrap;
    endproperty
    a_boot_strap: assert property (p_boot_strap) else $error("self boot without strap");
    property p_boot_closed;
        @(posedge clk_sys) disable iff (rst) selfBootBusy |-> !portActive && !wrStb && !rdStb;
    endproperty
    a_boot_closed: assert property (p_boot_closed) else $error("access during self boot");
    property p_boot_ends;
        @(posedge clk_sys) disable iff (rst) $rose(selfBootBusy) |-> ##[1:BootWin] !selfBootBusy;
    endproperty
    a_boot_ends: assert property (p_boot_ends) else $error("self boot too long");
    property p_host_write_open;
        @(posedge clk_sys) disable iff (rst) wrStb |-> portActive;
    endproperty
    a_host_write_open: assert property (p_host_write_open) else $error("host wrote to closed port");
endmodule : prs_link_properties

/* File: tb/powerup_reset_init_sequencer_bench.sv */
// powerup_reset_init_sequencer_bench: host/device pair plus a bench-driven device.
// assumes shortened lock and boot counts; inputs change on the falling edge.
`timescale 1ns/1ps
module powerup_reset_init_sequencer_bench;
    import prs_pkg::*;
    localparam int LockCyc = 16;
    localparam int BootCyc = 8;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    int errTotal = 0;
    int checks = 0;
    int cycles = 0;
    int i;
    int n;
    logic [15:0] d;
    logic ok;
    logic [3:0] supplyGood = 4'h0;
    logic hostGo = 1'b0;
    logic configured;
    logic hostBusy;
    logic coreRstA, lockedA, runA, coreRstB, romDoneB, lockedB, runB, gateB;
    logic [2:0] lsrB;
    logic [15:0] fbA, psA, srcA, fbB, psB, srcB;
    prs_port_mode_e modeA, modeB;
    logic [15:0] wv [0:2] = '{16'h1234, 16'h0002, 16'h0001};
    prs_link_if la ();
    prs_link_if lb ();
    always #5 clk_sys = ~clk_sys;
    prs_host u_prs_host (.clk_sys(clk_sys), .rst(rst), .link(la), .supplyGood(supplyGood), .clockRunning(hostGo),
        .resetRequestN(hostGo), .bootStrap(hostGo), .wantSpi(hostGo), .start(hostGo), .feedbackValue(16'h0070),
        .prescaleValue(16'h0002), .sourceValue(16'h0001), .busy(hostBusy), .configured(configured));
    prs_device #(.LockCycles(LockCyc), .BootCycles(BootCyc)) u_prs_device (.clk_sys(clk_sys), .rst(rst), .link(la),
        .levelShiftRst(), .coreRst(coreRstA), .pllClockGate(), .romDone(), .pllLocked(lockedA), .portMode(modeA),
        .pllFeedback(fbA), .pllPrescale(psA), .clockSource(srcA), .pllRun(runA));
    prs_device #(.LockCycles(LockCyc), .BootCycles(BootCyc)) u_prs_device_b (.clk_sys(clk_sys), .rst(rst), .link(lb),
        .levelShiftRst(lsrB), .coreRst(coreRstB), .pllClockGate(gateB), .romDone(romDoneB), .pllLocked(lockedB),
        .portMode(modeB), .pllFeedback(fbB), .pllPrescale(psB), .clockSource(srcB), .pllRun(runB));
    prs_link_properties #(.LockCycles(LockCyc), .BootCycles(BootCyc)) u_prs_link_properties (.clk_sys(clk_sys),
        .rst(rst), .porGood(la.porGood), .resetPinN(la.resetPinN), .masterClockValid(la.masterClockValid),
        .bootFromEepromStrap(la.bootFromEepromStrap), .wrStb(la.wrStb), .rdStb(la.rdStb), .addr(la.addr),
        .wrData(la.wrData), .rdValid(la.rdValid), .portActive(la.portActive), .selfBootBusy(la.selfBootBusy));
    task automatic stopTest;
        $display("checks %0d errors %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stopTest
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            errTotal++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk_sys);
        lb.addr = a;
        lb.wrData = v;
        lb.wrStb = 1'b1;
        @(negedge clk_sys);
        lb.wrStb = 1'b0;
    endtask : wr
    // rdValid and rdData stand one cycle, so they are taken at the next falling edge
    task automatic rd(input logic [15:0] a, output logic [15:0] v, output logic valid);
        @(negedge clk_sys);
        lb.addr = a;
        lb.rdStb = 1'b1;
        @(negedge clk_sys);
        lb.rdStb = 1'b0;
        valid = lb.rdValid;
        v = lb.rdData;
    endtask : rd
    task automatic toggleSelect;
        @(negedge clk_sys);
        lb.slaveSelectAddressPin = 1'b0;
        repeat (PRS_SS_MIN_CYCLES) @(negedge clk_sys);
        lb.slaveSelectAddressPin = 1'b1;
        repeat (PRS_SS_MIN_CYCLES) @(negedge clk_sys);
    endtask : toggleSelect
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            stopTest();
        end
    end
    initial begin
        lb.porGood = 4'h0;
        lb.resetPinN = 1'b1;
        lb.masterClockValid = 1'b1;
        lb.bootFromEepromStrap = 1'b0;
        lb.slaveSelectAddressPin = 1'b1;
        lb.wrStb = 1'b0;
        lb.rdStb = 1'b0;
        lb.addr = 16'h0000;
        lb.wrData = 16'h0000;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        for (i = 0; i < 16; i++) begin
            lb.porGood = i[3:0];
            repeat (6) @(negedge clk_sys);
            chk("levelShiftRst", {13'h0, ~({i[3], i[2], i[0]} & {3{i[1]}})}, {13'h0, lsrB});
            chk("coreRst", {15'h0, i != 15}, {15'h0, coreRstB});
            chk("pllClockGate", {15'h0, i[1] & i[2]}, {15'h0, gateB});
        end
        lb.resetPinN = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("coreRst pin low", 16'h1, {15'h0, coreRstB});
        lb.resetPinN = 1'b1;
        lb.masterClockValid = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("coreRst clock bad", 16'h1, {15'h0, coreRstB});
        lb.masterClockValid = 1'b1;
        for (n = 0; n < 20 && coreRstB !== 1'b0; n++) @(negedge clk_sys);
        chk("port closed in rom", 16'h0, {15'h0, lb.portActive});
        for (n = 0; n < 20 && romDoneB !== 1'b1; n++) @(negedge clk_sys);
        chk("rom cycles", PRS_ROM_STEPS[15:0], n[15:0]);
        @(negedge clk_sys);
        chk("port open", 16'h1, {15'h0, lb.portActive});
        chk("default mode", PRS_PORT_I2C, modeB);
        for (i = 0; i < 6; i++) begin
            rd(PRS_ADDR_PLL_FEEDBACK + i[15:0], d, ok);
            chk("read valid", 16'h1, {15'h0, ok});
            chk("reset value", (i == 0) ? PRS_FEEDBACK_RESET : PRS_ZERO_RESET, d);
        end
        for (i = 0; i < 3; i++) wr(PRS_ADDR_PLL_FEEDBACK + i[15:0], wv[i]);
        wr(PRS_ADDR_PLL_LOCKED, 16'hffff);
        for (i = 0; i < 3; i++) begin
            rd(PRS_ADDR_PLL_FEEDBACK + i[15:0], d, ok);
            chk("config readback", wv[i], d);
        end
        rd(PRS_ADDR_PLL_LOCKED, d, ok);
        chk("status read only", 16'h0, d);
        chk("feedback pins", wv[0], fbB);
        chk("prescale pins", wv[1], psB);
        chk("source pins", wv[2], srcB);
        wr(PRS_ADDR_PLL_RUN, 16'h0001);
        // run lands on the write edge, the lock state begins one edge later
        @(negedge clk_sys);
        chk("port closed lock", 16'h0, {15'h0, lb.portActive});
        chk("not locked yet", 16'h0, {15'h0, lockedB});
        wr(PRS_ADDR_PLL_FEEDBACK, 16'h5555);
        rd(PRS_ADDR_PLL_FEEDBACK, d, ok);
        chk("read refused", 16'h0, {15'h0, ok});
        for (n = 0; n < 200 && lb.portActive !== 1'b1; n++) @(negedge clk_sys);
        chk("lock in time", 16'h1, {15'h0, n <= LockCyc});
        chk("locked pin", 16'h1, {15'h0, lockedB});
        rd(PRS_ADDR_PLL_LOCKED, d, ok);
        chk("lock bit", 16'h1, {15'h0, d[PRS_LOCK_BIT]});
        rd(PRS_ADDR_PLL_FEEDBACK, d, ok);
        chk("write dropped", wv[0], d);
        toggleSelect();
        toggleSelect();
        repeat (5) @(negedge clk_sys);
        chk("two toggles", PRS_PORT_I2C, modeB);
        toggleSelect();
        repeat (5) @(negedge clk_sys);
        chk("third rise", PRS_PORT_SPI, modeB);
        lb.resetPinN = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("mode after reset", PRS_PORT_I2C, modeB);
        chk("run cleared", 16'h0, {15'h0, runB});
        lb.bootFromEepromStrap = 1'b1;
        lb.resetPinN = 1'b1;
        for (n = 0; n < 40 && lb.selfBootBusy !== 1'b1; n++) @(negedge clk_sys);
        chk("self boot", 16'h1, {15'h0, lb.selfBootBusy});
        for (n = 0; n < 100 && lb.portActive !== 1'b1; n++) @(negedge clk_sys);
        chk("boot length", 16'h1, {15'h0, n >= BootCyc && lb.selfBootBusy === 1'b0});
        supplyGood = 4'hf;
        hostGo = 1'b1;
        for (n = 0; n < 2000 && configured !== 1'b1; n++) @(negedge clk_sys);
        chk("host configured", 16'h1, {15'h0, configured});
        chk("host busy", 16'h0, {15'h0, hostBusy});
        chk("host feedback", 16'h0070, fbA);
        chk("host prescale", 16'h0002, psA);
        chk("host source", 16'h0001, srcA);
        chk("host locked", 16'h1, {15'h0, lockedA & runA});
        chk("host spi", PRS_PORT_SPI, modeA);
        supplyGood = 4'hd;
        repeat (6) @(negedge clk_sys);
        chk("host core reset", 16'h1, {15'h0, coreRstA});
        chk("host run cleared", 16'h0, {15'h0, runA});
        stopTest();
    end
endmodule : powerup_reset_init_sequencer_bench
